// file: rtl/tgs_consts.svh
/*
  Constants for the tach/general-line select and prescale block:
  register offsets, field positions, reset values and timing counts.
  Assumes it is included by bare name from rtl/ sources.
*/
`ifndef TGS_CONSTS_SVH
`define TGS_CONSTS_SVH

// register offsets on the management port
`define TGS_PIN_SEL_OFS      8'h01
`define TGS_DIV_OFS          8'h02

// power-on values
`define TGS_PIN_SEL_RST      8'h00
`define TGS_DIV_RST          8'h55

// field layout of the divisor register: two bits per channel
`define TGS_DIV_FIELD_W      2
`define TGS_DIV_CHANNELS     4

// number of shared lines
`define TGS_LINES            8

// timing: core clock and base counting-oscillator rate, in Hz
`define TGS_MCLK_HZ          20000000
`define TGS_OSC_BASE_HZ      22500
// cycles per base oscillator tick, rounded down, so the period is a little short
`define TGS_OSC_BASE_CYC     (`TGS_MCLK_HZ / `TGS_OSC_BASE_HZ)
`define TGS_OSC_CNT_W        10

// nominal speed at divide-by-1 for a count of 153, two pulses per turn
`define TGS_NOM_COUNT        153
`define TGS_NOM_RPM          8800

`endif

// file: rtl/tgs_pkg.sv
/*
  Types for the tach/general-line select and prescale block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package tgs_pkg;

  // divisor code of one tach channel
  typedef enum logic [1:0]
  {
    TGS_DIV1 = 2'h0,
    TGS_DIV2 = 2'h1,
    TGS_DIV4 = 2'h2,
    TGS_DIV8 = 2'h3
  } tgs_div_e;

  typedef logic [7:0] tgs_byte_t;

endpackage : tgs_pkg
`default_nettype wire

// file: rtl/tgs_prescaler.sv
/*
  Counting-oscillator prescaler: a base tick from the core clock and
  one divided tick per tach channel, chosen by its divisor code.
  Assumes mclk at 20 MHz and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tgs_consts.svh"

module tgs_prescaler
(
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire tgs_pkg::tgs_div_e               div_code [`TGS_DIV_CHANNELS],
  output var  logic [`TGS_DIV_CHANNELS-1:0]    osc_tick
);
  import tgs_pkg::*;

  localparam logic [`TGS_OSC_CNT_W-1:0] BASE_LAST =
    `TGS_OSC_CNT_W'(`TGS_OSC_BASE_CYC - 1);

  logic [`TGS_OSC_CNT_W-1:0]   base_cnt_reg;
  logic [`TGS_OSC_CNT_W-1:0]   base_cnt_next;
  logic                        base_tick;
  logic [2:0]                  oct_reg;
  logic [2:0]                  oct_next;
  logic [`TGS_DIV_CHANNELS-1:0] tick_next;
  logic [`TGS_DIV_CHANNELS-1:0] tick_reg;

  // base 22.5 kHz tick and a 3-bit octave counter for divide by 1..8
  always_comb
  begin
    base_tick     = (base_cnt_reg == BASE_LAST);
    base_cnt_next = base_tick ? '0 : base_cnt_reg + 1'b1;
    oct_next      = base_tick ? oct_reg + 3'h1 : oct_reg;
  end

  // per-channel divided tick; code n keeps one tick in 2**n
  for (genvar c = 0; c < `TGS_DIV_CHANNELS; c++)
  begin : g_chan
    logic [2:0] mask;
    always_comb
    begin
      unique case (div_code[c])                  // RULE6 RULE8
        TGS_DIV1: mask = 3'h0;
        TGS_DIV2: mask = 3'h1;
        TGS_DIV4: mask = 3'h3;
        TGS_DIV8: mask = 3'h7;
      endcase
      tick_next[c] = base_tick && ((oct_reg & mask) == 3'h0); // RULE7
    end
  end

  // register counters and ticks
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      base_cnt_reg <= '0;
      oct_reg      <= 3'h0;
      tick_reg     <= '0;
    end
    else
    begin
      base_cnt_reg <= base_cnt_next;
      oct_reg      <= oct_next;
      tick_reg     <= tick_next;
    end
  end

  assign osc_tick = tick_reg;

endmodule : tgs_prescaler
`default_nettype wire

// file: rtl/tgs_top.sv
/*
  Shared-line function select and tach oscillator prescale.
  Eight shared lines go either to tach inputs or to general lines;
  tach channels 0..3 get a counting-oscillator tick at a chosen rate.
  Assumes a plain register port on mclk, and tach counters and
  general-line logic on the same clock outside this block.
*/
// What this block does
// RULE1 - pin_sel bit 0: line 0 general, else tach 0
// RULE2 - pin_sel bit 1: line 1 general, else tach 1
// RULE3 - pin_sel bit 2: line 2 general, else tach 2
// RULE4 - pin_sel bit 3: line 3 general, else tach 3
// RULE5 - pin_sel bits 4-7 select lines 4-7 likewise
// RULE6 - divisor bits 1-0 set tach 0 oscillator rate
// RULE7 - count 153 at divide-by-1 means 8800 RPM
// RULE8 - divisor pairs 3-2,5-4,7-6 set tach 1-3
`timescale 1ns/1ps
`default_nettype none
`include "tgs_consts.svh"

module tgs_top
(
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire tgs_pkg::tgs_byte_t            reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  tgs_pkg::tgs_byte_t            reg_rdata,
  // shared pins, three signals each
  input  wire logic [`TGS_LINES-1:0]         line_pin_in,
  output var  logic [`TGS_LINES-1:0]         line_pin_out,
  output var  logic [`TGS_LINES-1:0]         line_pin_oe,
  // general-line side
  input  wire logic [`TGS_LINES-1:0]         general_line_out,
  input  wire logic [`TGS_LINES-1:0]         general_line_drive,
  output var  logic [`TGS_LINES-1:0]         general_line_in,
  // tach side
  output var  logic [`TGS_LINES-1:0]         tach_in,
  output var  logic [`TGS_LINES-1:0]         tach_enabled,
  output var  logic [`TGS_DIV_CHANNELS-1:0]  tach_osc_tick
);
  import tgs_pkg::*;

  tgs_byte_t                    pin_sel_reg;
  tgs_byte_t                    pin_sel_next;
  tgs_byte_t                    div_reg;
  tgs_byte_t                    div_next;
  tgs_byte_t                    rdata_reg;
  tgs_byte_t                    rdata_next;
  tgs_byte_t                    tach_en_reg;
  tgs_byte_t                    tach_en_next;
  tgs_div_e                     div_code [`TGS_DIV_CHANNELS];

  logic [`TGS_LINES-1:0]        sync1_reg;
  logic [`TGS_LINES-1:0]        sync2_reg;
  logic [`TGS_LINES-1:0]        sync3_reg;
  logic [`TGS_LINES-1:0]        filt_reg;
  logic [`TGS_LINES-1:0]        filt_next;
  logic [`TGS_LINES-1:0]        tach_next;
  logic [`TGS_LINES-1:0]        tach_reg;
  logic [`TGS_LINES-1:0]        gin_next;
  logic [`TGS_LINES-1:0]        gin_reg;
  logic [`TGS_LINES-1:0]        out_next;
  logic [`TGS_LINES-1:0]        out_reg;
  logic [`TGS_LINES-1:0]        oe_next;
  logic [`TGS_LINES-1:0]        oe_reg;

  // register writes and read mux; unmapped reads answer zero
  always_comb
  begin
    pin_sel_next = pin_sel_reg;
    div_next     = div_reg;
    rdata_next   = 8'h00;
    if (reg_wr && reg_addr == `TGS_PIN_SEL_OFS)
      pin_sel_next = reg_wdata;                  // RULE1 RULE2 RULE3 RULE4 RULE5
    if (reg_wr && reg_addr == `TGS_DIV_OFS)
      div_next = reg_wdata;                      // RULE6 RULE8
    // tach-enable flags kept in their own flops so the output is a register
    tach_en_next = ~pin_sel_next;                // RULE1 RULE2 RULE3 RULE4 RULE5
    if (reg_rd)
    begin
      unique case (reg_addr)
        `TGS_PIN_SEL_OFS: rdata_next = pin_sel_reg;
        `TGS_DIV_OFS:     rdata_next = div_reg;
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  // register file, power-on defaults on reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_sel_reg <= `TGS_PIN_SEL_RST;
      div_reg     <= `TGS_DIV_RST;
      rdata_reg   <= 8'h00;
      tach_en_reg <= ~`TGS_PIN_SEL_RST;
    end
    else
    begin
      pin_sel_reg <= pin_sel_next;
      div_reg     <= div_next;
      rdata_reg   <= rdata_next;
      tach_en_reg <= tach_en_next;
    end
  end

  // split the divisor register into per-channel codes
  for (genvar c = 0; c < `TGS_DIV_CHANNELS; c++)
  begin : g_div
    assign div_code[c] = tgs_div_e'(div_reg[c*`TGS_DIV_FIELD_W +: `TGS_DIV_FIELD_W]);
  end

  // per-line routing; a line set to 1 is a general line, else tach
  for (genvar i = 0; i < `TGS_LINES; i++)
  begin : g_line
    always_comb
    begin
      filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
      tach_next[i] = pin_sel_reg[i] ? 1'b0 : filt_reg[i];  // RULE1 RULE2 RULE3 RULE4 RULE5
      gin_next[i]  = pin_sel_reg[i] ? filt_reg[i] : 1'b0;  // RULE1 RULE2 RULE3 RULE4 RULE5
      oe_next[i]   = pin_sel_reg[i] & general_line_drive[i];
      out_next[i]  = pin_sel_reg[i] & general_line_out[i];
    end
  end

  // pin synchroniser, filter and registered routing outputs
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
      tach_reg  <= '0;
      gin_reg   <= '0;
      out_reg   <= '0;
      oe_reg    <= '0;
    end
    else
    begin
      sync1_reg <= line_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
      tach_reg  <= tach_next;
      gin_reg   <= gin_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  // tach counting-oscillator ticks per channel
  tgs_prescaler u_prescaler
  (
    .mclk     (mclk),
    .resetn   (resetn),
    .div_code (div_code),
    .osc_tick (tach_osc_tick)                    // RULE6 RULE7 RULE8
  );

  assign reg_rdata       = rdata_reg;
  assign line_pin_out    = out_reg;
  assign line_pin_oe     = oe_reg;
  assign general_line_in = gin_reg;
  assign tach_in         = tach_reg;
  assign tach_enabled    = tach_en_reg;

endmodule : tgs_top
`default_nettype wire

// file: dv/tgs_top_assertions.sv
/* port relations of tgs_top
   bound to every tgs_top instance; sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module tgs_top_chk
(
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic [7:0]         reg_addr,
  input wire tgs_pkg::tgs_byte_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire tgs_pkg::tgs_byte_t reg_rdata,
  input wire logic [7:0]         line_pin_in,
  input wire logic [7:0]         line_pin_out,
  input wire logic [7:0]         line_pin_oe,
  input wire logic [7:0]         general_line_out,
  input wire logic [7:0]         general_line_drive,
  input wire logic [7:0]         general_line_in,
  input wire logic [7:0]         tach_in,
  input wire logic [7:0]         tach_enabled,
  input wire logic [3:0]         tach_osc_tick
);
  import tgs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0]  dv_reg;
  logic [12:0] gap_reg [4];
  logic [1:0]  ok_reg [4];
  // divisor shadow and cycles since each channel's last tick
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dv_reg <= 8'h55;
    else if (reg_wr && reg_addr == 8'h02)
      dv_reg <= reg_wdata;
    for (int c = 0; c < 4; c++)
    begin
      gap_reg[c] <= (!resetn || tach_osc_tick[c]) ? 13'h1 : gap_reg[c] + 13'h1;
      // a tick already in flight at a divisor write is stale, so the two
      // gaps that follow a write are skipped
      if (!resetn || (reg_wr && reg_addr == 8'h02))
        ok_reg[c] <= 2'h0;
      else if (tach_osc_tick[c] && ok_reg[c] != 2'h2)
        ok_reg[c] <= ok_reg[c] + 2'h1;
    end
  end
  sel_low_a: assert property (reg_wr && reg_addr == 8'h01 |=>
    tach_enabled[3:0] == ~$past(reg_wdata[3:0])) else $error("low select wrong");
  sel_high_a: assert property (reg_wr && reg_addr == 8'h01 |=>
    tach_enabled[7:4] == ~$past(reg_wdata[7:4])) else $error("high select wrong");
  out_gate_a: assert property (1'b1 |=>
    line_pin_out == ($past(general_line_out) & ~$past(tach_enabled))) else $error("pin out");
  oe_gate_a: assert property (1'b1 |=>
    line_pin_oe == ($past(general_line_drive) & ~$past(tach_enabled))) else $error("pin oe");
  split_a: assert property (1'b1 |=>
    ((tach_in & ~$past(tach_enabled)) | (general_line_in & $past(tach_enabled))) == 8'h00)
    else $error("input on wrong side");
  pin_path_a: assert property (($stable(line_pin_in) && $stable(tach_enabled)) [*6] |->
    (tach_in | general_line_in) == line_pin_in) else $error("pin level lost");
  rd_sel_a: assert property (reg_rd && reg_addr == 8'h01 |=>
    reg_rdata == ~$past(tach_enabled)) else $error("select readback");
  div0_gap_a: assert property (tach_osc_tick[0] && ok_reg[0] == 2'h2 |->
    gap_reg[0] == (13'h378 << dv_reg[1:0])) else $error("tach 0 rate");
  div1_gap_a: assert property (tach_osc_tick[1] && ok_reg[1] == 2'h2 |->
    gap_reg[1] == (13'h378 << dv_reg[3:2])) else $error("tach 1 rate");
  div2_gap_a: assert property (tach_osc_tick[2] && ok_reg[2] == 2'h2 |->
    gap_reg[2] == (13'h378 << dv_reg[5:4])) else $error("tach 2 rate");
  div3_gap_a: assert property (tach_osc_tick[3] && ok_reg[3] == 2'h2 |->
    gap_reg[3] == (13'h378 << dv_reg[7:6])) else $error("tach 3 rate");
  c_wsel: cover property (reg_wr && reg_addr == 8'h01);
  c_tick: cover property (tach_osc_tick[0] && ok_reg[0] == 2'h2);
  c_rdiv: cover property (reg_rd && reg_addr == 8'h02);
endmodule : tgs_top_chk
bind tgs_top tgs_top_chk u_chk (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .line_pin_in, .line_pin_out, .line_pin_oe, .general_line_out,
  .general_line_drive, .general_line_in, .tach_in, .tach_enabled, .tach_osc_tick);
`default_nettype wire

// file: dv/tb_tgs_top.sv
/* self-checking bench for tgs_top
   drives register port and pins; checker is bound alongside */
`timescale 1ns/1ps
`default_nettype none
module tb_tgs_top;
  import tgs_pkg::*;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  tgs_byte_t  reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  tgs_byte_t  reg_rdata;
  logic [7:0] line_pin_in = 8'h96;
  logic [7:0] general_line_out = 8'hc3;
  logic [7:0] general_line_drive = 8'h5a;
  logic [7:0] line_pin_out, line_pin_oe, general_line_in, tach_in, tach_enabled;
  logic [3:0] tach_osc_tick;
  int         n_errors = 0;
  int         tests_run = 0;
  tgs_top uut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_pin_in, .line_pin_out, .line_pin_oe, .general_line_out, .general_line_drive,
    .general_line_in, .tach_in, .tach_enabled, .tach_osc_tick);
  // 20 MHz core clock
  always #25 mclk = ~mclk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input tgs_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input tgs_byte_t e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // data stand in the cycle after the strobe; read them at its closing edge
    @(posedge mclk);
    chk(reg_rdata, e, "reg_rdata");
  endtask : rd
  // skip one tick, then count cycles to the next
  task automatic gap(input int ch, input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0;
    do @(posedge mclk); while (tach_osc_tick[ch] !== 1'b1);
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (tach_osc_tick[ch] !== 1'b1);
    chk(n, e, "tick gap");
  endtask : gap
  task automatic results();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    tgs_byte_t m, nm;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h55);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      nm = ~m;
      wr(8'h01, m);
      rd(8'h01, m);
      chk(tach_enabled, nm, "tach_enabled");
      repeat (6) @(posedge mclk);
      chk(line_pin_out, general_line_out & m, "line_pin_out");
      chk(line_pin_oe, general_line_drive & m, "line_pin_oe");
      chk(general_line_in, line_pin_in & m, "general_line_in");
      chk(tach_in, line_pin_in & nm, "tach_in");
    end
    for (int c = 0; c < 4; c++)
    begin
      m = {2'(3 - c), 2'(c), 2'(3 - c), 2'(c)};
      wr(8'h02, m);
      rd(8'h02, m);
      gap(0, 16'h378 << c);
      gap(3, 16'h378 << (3 - c));
    end
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(8'h01, 8'h80);
    rd(8'h02, 8'h33);
    results();
  end
  // hang guard
  initial
  begin
    repeat (80000) @(posedge mclk);
    n_errors++;
    results();
  end
endmodule : tb_tgs_top
`default_nettype wire
